// ### src/cca_top.sv
`timescale 1ns/1ps
`include "cca_params.svh"

// Notes on behaviour
// RULE_01: Memory increment reads the byte, adds one, writes it back to that address.
// RULE_02: Counter results stay eight bits; 255 plus one wraps to 0.
// RULE_03: Index increments use no operand address; they add one to X or Y.
// RULE_04: Memory increment supports absolute mode with a full 16-bit address; mem_addr carries only its low MEM_AW bits, all 16 only when MEM_AW is 16.
// RULE_05: Decrements mirror increments but subtract one from the target.
// RULE_06: Compare subtracts operand from register for flags only; nothing is written.
// RULE_07: Three compares use accumulator, X or Y as the register operand.
// RULE_08: Each compare accepts immediate, zero-page and absolute operands.
// RULE_09: The accumulator receives every add, subtract, AND, inclusive or and exclusive or result.
// RULE_10: Add forms accumulator plus operand plus carry into the accumulator.
// RULE_11: Subtract removes operand and borrow (inverse carry) from the accumulator.
// RULE_12: AND combines accumulator and operand bitwise into the accumulator.
// RULE_13: Exclusive or gives one where exactly one bit is one.
// RULE_14: Inclusive or combines operand and accumulator bitwise into the accumulator.
// RULE_15: Bit test copies operand bit 7 to negative and bit 6 to overflow.
// RULE_16: Software should clear carry before an addition.
// RULE_17: Software should set carry before a subtraction.
// RULE_18: Bit test sets zero when accumulator AND operand is zero.
// RULE_19: Bit test leaves the accumulator, X and Y unchanged.
// RULE_20: Compare sets zero on equal, carry on unsigned greater or equal, negative from bit 7.
// RULE_21: Counter and logical results set zero and negative from the result.

module cca_top #(
	parameter int MEM_AW = 16
) (
	input logic clk,
	input logic rst,
	input logic [3:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [MEM_AW-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input logic [7:0] mem_rdata,
	output logic busy
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (MEM_AW < 9 || MEM_AW > 16) begin : g_bad_width
		$error("MEM_AW must lie between 9 and 16");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	cca_pkg::cca_state_e state, next_state;
	cca_pkg::cca_op_e op, next_op;
	cca_pkg::cca_mode_e mode, next_mode;
	cca_pkg::cca_byte_t acc, x_idx, y_idx, imm, addr_lo, addr_hi, fetched, result;
	cca_pkg::cca_byte_t next_acc, next_x_idx, next_y_idx, next_imm, next_addr_lo;
	cca_pkg::cca_byte_t next_addr_hi, next_fetched, next_result, next_mem_wdata, next_reg_rdata;
	logic flag_n, flag_v, flag_z, flag_c;
	logic next_flag_n, next_flag_v, next_flag_z, next_flag_c;
	logic next_mem_rd, next_mem_wr, next_busy;
	logic [MEM_AW-1:0] next_mem_addr;

	// ----------------------------------------
	// Command decode and operand selection
	// ----------------------------------------
	cca_pkg::cca_op_e cmd_op;
	logic cmd_start, cmd_fetch;
	logic [15:0] eff_addr;
	cca_pkg::cca_byte_t opv, alu_res;
	logic alu_n, alu_v, alu_z, alu_c;
	logic wr_a, wr_x, wr_y, wr_mem, upd_nz, upd_v, upd_c;

	assign cmd_op = cca_pkg::cca_op_e'(reg_wdata[4:0]);
	// Counter ops on memory have no immediate form, so such a command never starts.
	assign cmd_start = reg_wr && (reg_addr == `CCA_REG_CMD) && (state == cca_pkg::st_idle) &&
		(reg_wdata[4:0] <= cca_pkg::op_set_carry_op) &&
		!(cca_pkg::is_rmw(cmd_op) && (mode == cca_pkg::mode_immediate));
	assign cmd_fetch = cca_pkg::uses_memory(cmd_op) && (mode != cca_pkg::mode_immediate); // RULE_08
	assign eff_addr = (mode == cca_pkg::mode_zero_page) ? {8'h00, addr_lo} : {addr_hi, addr_lo}; // RULE_04
	assign opv = (mode == cca_pkg::mode_immediate) ? imm : fetched;

	cca_alu u_alu (
		.op(op),
		.a(acc),
		.x(x_idx),
		.y(y_idx),
		.opv(opv),
		.c_in(flag_c),
		.res(alu_res),
		.n(alu_n),
		.v(alu_v),
		.z(alu_z),
		.c(alu_c),
		.wr_a(wr_a),
		.wr_x(wr_x),
		.wr_y(wr_y),
		.wr_mem(wr_mem),
		.upd_nz(upd_nz),
		.upd_v(upd_v),
		.upd_c(upd_c)
	);

	// ----------------------------------------
	// Sequencer and register file
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_op = op;
		next_mode = mode;
		next_acc = acc;
		next_x_idx = x_idx;
		next_y_idx = y_idx;
		next_imm = imm;
		next_addr_lo = addr_lo;
		next_addr_hi = addr_hi;
		next_fetched = fetched;
		next_result = result;
		next_flag_n = flag_n;
		next_flag_v = flag_v;
		next_flag_z = flag_z;
		next_flag_c = flag_c;
		next_mem_rd = 1'b0;
		next_mem_wr = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_busy = busy;
		unique case (state)
			cca_pkg::st_idle: begin
				// Writes during an operation are dropped so operands cannot shift under it.
				if (reg_wr) begin
					case (reg_addr)
						`CCA_REG_ACC: next_acc = reg_wdata;
						`CCA_REG_X: next_x_idx = reg_wdata;
						`CCA_REG_Y: next_y_idx = reg_wdata;
						`CCA_REG_STATUS: begin
							next_flag_n = reg_wdata[`CCA_ST_N];
							next_flag_v = reg_wdata[`CCA_ST_V];
							next_flag_z = reg_wdata[`CCA_ST_Z];
							next_flag_c = reg_wdata[`CCA_ST_C];
						end
						`CCA_REG_IMM: next_imm = reg_wdata;
						`CCA_REG_ADDR_LO: next_addr_lo = reg_wdata;
						`CCA_REG_ADDR_HI: next_addr_hi = reg_wdata;
						`CCA_REG_MODE: begin
							if (reg_wdata[1:0] <= cca_pkg::mode_absolute) begin
								next_mode = cca_pkg::cca_mode_e'(reg_wdata[1:0]);
							end
						end
						default: begin
							next_busy = busy;
						end
					endcase
				end
				if (cmd_start) begin
					next_op = cmd_op;
					next_busy = 1'b1;
					if (cmd_fetch) begin
						next_mem_rd = 1'b1; // RULE_01
						next_mem_addr = eff_addr[MEM_AW-1:0];
						next_state = cca_pkg::st_read;
					end else begin
						next_state = cca_pkg::st_exec; // RULE_03
					end
				end
			end
			cca_pkg::st_read: begin
				next_state = cca_pkg::st_capture;
			end
			cca_pkg::st_capture: begin
				next_fetched = mem_rdata;
				next_state = cca_pkg::st_exec;
			end
			cca_pkg::st_exec: begin
				next_result = alu_res;
				if (wr_a) begin
					next_acc = alu_res; // RULE_09
				end
				if (wr_x) begin
					next_x_idx = alu_res;
				end
				if (wr_y) begin
					next_y_idx = alu_res;
				end
				if (upd_nz) begin
					next_flag_n = alu_n; // RULE_21
					next_flag_z = alu_z; // RULE_20
				end
				if (upd_v) begin
					next_flag_v = alu_v;
				end
				if (upd_c) begin
					next_flag_c = alu_c;
				end
				if (wr_mem) begin
					next_mem_wr = 1'b1; // RULE_01
					next_mem_wdata = alu_res;
					next_state = cca_pkg::st_write;
				end else begin
					next_busy = 1'b0;
					next_state = cca_pkg::st_idle;
				end
			end
			cca_pkg::st_write: begin
				next_busy = 1'b0;
				next_state = cca_pkg::st_idle;
			end
			default: begin
				next_busy = 1'b0;
				next_state = cca_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= cca_pkg::st_idle;
			op <= cca_pkg::op_none;
			mode <= cca_pkg::mode_immediate;
			acc <= `CCA_RST_BYTE;
			x_idx <= `CCA_RST_BYTE;
			y_idx <= `CCA_RST_BYTE;
			imm <= `CCA_RST_BYTE;
			addr_lo <= `CCA_RST_BYTE;
			addr_hi <= `CCA_RST_BYTE;
			fetched <= `CCA_RST_BYTE;
			result <= `CCA_RST_BYTE;
			flag_n <= `CCA_RST_FLAG;
			flag_v <= `CCA_RST_FLAG;
			flag_z <= `CCA_RST_FLAG;
			flag_c <= `CCA_RST_FLAG;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= `CCA_RST_BYTE;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			mode <= next_mode;
			acc <= next_acc;
			x_idx <= next_x_idx;
			y_idx <= next_y_idx;
			imm <= next_imm;
			addr_lo <= next_addr_lo;
			addr_hi <= next_addr_hi;
			fetched <= next_fetched;
			result <= next_result;
			flag_n <= next_flag_n;
			flag_v <= next_flag_v;
			flag_z <= next_flag_z;
			flag_c <= next_flag_c;
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			busy <= next_busy;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_comb begin
		next_reg_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`CCA_REG_ACC: next_reg_rdata = acc;
				`CCA_REG_X: next_reg_rdata = x_idx;
				`CCA_REG_Y: next_reg_rdata = y_idx;
				`CCA_REG_STATUS: begin
					next_reg_rdata[`CCA_ST_N] = flag_n;
					next_reg_rdata[`CCA_ST_V] = flag_v;
					next_reg_rdata[`CCA_ST_Z] = flag_z;
					next_reg_rdata[`CCA_ST_C] = flag_c;
				end
				`CCA_REG_IMM: next_reg_rdata = imm;
				`CCA_REG_ADDR_LO: next_reg_rdata = addr_lo;
				`CCA_REG_ADDR_HI: next_reg_rdata = addr_hi;
				`CCA_REG_MODE: next_reg_rdata[1:0] = mode;
				`CCA_REG_CMD: begin
					next_reg_rdata[4:0] = op;
					next_reg_rdata[`CCA_CMD_BUSY] = busy;
				end
				`CCA_REG_RESULT: next_reg_rdata = result;
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic in_exec;
	assign in_exec = state == cca_pkg::st_exec;

	sequence s_fetch_start;
		cmd_start && cmd_fetch;
	endsequence

	sequence s_read_steps;
		mem_rd && busy ##1 !mem_rd && state == cca_pkg::st_capture ##1 in_exec;
	endsequence

	a_fetch_walk: assert property (@(posedge clk) disable iff (rst) // RULE_08
		s_fetch_start |=> s_read_steps)
		else $error("operand fetch did not follow read, capture, execute");
	a_rmw_same_addr: assert property (@(posedge clk) disable iff (rst) // RULE_01
		$rose(mem_wr) |-> $past(mem_rd, 3) && mem_addr == $past(mem_addr, 3))
		else $error("write-back address differs from fetch address");
	a_mem_inc_write: assert property (@(posedge clk) disable iff (rst) // RULE_01
		in_exec && op == cca_pkg::op_memory_plus_one |=>
		mem_wr && mem_wdata == 8'($past(opv) + 8'h01) ##1 !mem_wr && !busy)
		else $error("memory increment wrote a wrong value");
	a_mem_minus_write: assert property (@(posedge clk) disable iff (rst) // RULE_05
		in_exec && op == cca_pkg::op_memory_minus_one |=>
		mem_wr && mem_wdata == 8'($past(opv) - 8'h01))
		else $error("memory decrement wrote a wrong value");
	a_counter_wrap: assert property (@(posedge clk) disable iff (rst) // RULE_02
		in_exec && op == cca_pkg::op_x_index_plus_one && x_idx == 8'hff |=>
		x_idx == 8'h00 && flag_z && !flag_n)
		else $error("index increment did not wrap to zero");
	a_index_no_fetch: assert property (@(posedge clk) disable iff (rst) // RULE_03
		cmd_start && (cmd_op == cca_pkg::op_x_index_plus_one ||
		cmd_op == cca_pkg::op_y_index_plus_one) |=> in_exec && !mem_rd ##1 !mem_wr && !busy)
		else $error("index increment touched memory");
	a_abs_address: assert property (@(posedge clk) disable iff (rst) // RULE_04
		(s_fetch_start and (mode == cca_pkg::mode_absolute)) |=>
		mem_rd && mem_addr == MEM_AW'({$past(addr_hi), $past(addr_lo)}))
		else $error("absolute operand address wrong");
	a_zero_page_addr: assert property (@(posedge clk) disable iff (rst) // RULE_08
		(s_fetch_start and (mode == cca_pkg::mode_zero_page)) |=>
		mem_rd && mem_addr == MEM_AW'($past(addr_lo)))
		else $error("zero-page operand address wrong");
	a_compare_keeps: assert property (@(posedge clk) disable iff (rst) // RULE_06
		in_exec && op >= cca_pkg::op_compare_accumulator && op <= cca_pkg::op_compare_y_index |=>
		$stable(acc) && $stable(x_idx) && $stable(y_idx) && !mem_wr && !busy)
		else $error("compare modified a register or memory");
	a_compare_flags: assert property (@(posedge clk) disable iff (rst) // RULE_20
		in_exec && op == cca_pkg::op_compare_y_index |=>
		flag_c == ($past(y_idx) >= $past(opv)) && flag_z == ($past(y_idx) == $past(opv)))
		else $error("compare flags wrong");
	a_adc_sum: assert property (@(posedge clk) disable iff (rst) // RULE_10
		in_exec && op == cca_pkg::op_add_with_carry |=>
		acc == 8'($past(acc) + $past(opv) + {7'h00, $past(flag_c)}))
		else $error("add with carry result wrong");
	a_borrow_diff: assert property (@(posedge clk) disable iff (rst) // RULE_11
		in_exec && op == cca_pkg::op_subtract_with_borrow |=>
		acc == 8'($past(acc) - $past(opv) - {7'h00, !$past(flag_c)}))
		else $error("subtract with borrow result wrong");
	a_logic_ops: assert property (@(posedge clk) disable iff (rst) // RULE_13
		in_exec && op == cca_pkg::op_exclusive_or |=> acc == ($past(acc) ^ $past(opv)) ##1
		$stable(acc))
		else $error("exclusive or result wrong");
	a_and_or_ops: assert property (@(posedge clk) disable iff (rst) // RULE_12
		in_exec && (op == cca_pkg::op_and_acc || op == cca_pkg::op_inclusive_or_accumulate) |=>
		acc == (($past(op) == cca_pkg::op_and_acc) ? ($past(acc) & $past(opv)) :
		($past(acc) | $past(opv))))
		else $error("and or result wrong");
	a_bit_flags: assert property (@(posedge clk) disable iff (rst) // RULE_15
		in_exec && op == cca_pkg::op_bit_test |=>
		flag_n == (($past(opv) & 8'h80) != 8'h00) && flag_v == (($past(opv) & 8'h40) != 8'h00) &&
		flag_z == (($past(acc) & $past(opv)) == 8'h00) && $stable(acc))
		else $error("bit test flags wrong or accumulator changed");
	a_result_flags: assert property (@(posedge clk) disable iff (rst) // RULE_21
		in_exec && op >= cca_pkg::op_memory_plus_one && op <= cca_pkg::op_y_index_minus_one |=>
		flag_z == (result == 8'h00) && flag_n == (result >= 8'h80))
		else $error("counter flags wrong");

endmodule

// ### inc/cca_params.svh
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCA_REG_ACC 4'h0
`define CCA_REG_X 4'h1
`define CCA_REG_Y 4'h2
`define CCA_REG_STATUS 4'h3
`define CCA_REG_IMM 4'h4
`define CCA_REG_ADDR_LO 4'h5
`define CCA_REG_ADDR_HI 4'h6
`define CCA_REG_MODE 4'h7
`define CCA_REG_CMD 4'h8
`define CCA_REG_RESULT 4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCA_ST_N 7
`define CCA_ST_V 6
`define CCA_ST_Z 1
`define CCA_ST_C 0
`define CCA_CMD_BUSY 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCA_RST_BYTE 8'h00
`define CCA_RST_FLAG 1'b0

`endif

// ### inc/cca_pkg.sv
package cca_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [7:0] cca_byte_t;

	typedef enum logic [4:0] {
		op_add_with_carry,
		op_subtract_with_borrow,
		op_and_acc,
		op_inclusive_or_accumulate,
		op_exclusive_or,
		op_bit_test,
		op_compare_accumulator,
		op_compare_x_index,
		op_compare_y_index,
		op_memory_plus_one,
		op_memory_minus_one,
		op_x_index_plus_one,
		op_x_index_minus_one,
		op_y_index_plus_one,
		op_y_index_minus_one,
		op_clear_carry_op,
		op_set_carry_op,
		op_none
	} cca_op_e;

	typedef enum logic [1:0] {
		mode_immediate,
		mode_zero_page,
		mode_absolute
	} cca_mode_e;

	typedef enum logic [2:0] {
		st_idle,
		st_read,
		st_capture,
		st_exec,
		st_write
	} cca_state_e;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic logic uses_memory(input cca_op_e op);
		return op <= op_memory_minus_one;
	endfunction

	function automatic logic is_rmw(input cca_op_e op);
		return (op == op_memory_plus_one) || (op == op_memory_minus_one);
	endfunction

endpackage

// ### src/cca_alu.sv
`timescale 1ns/1ps

module cca_alu (
	input logic [4:0] op,
	input logic [7:0] a,
	input logic [7:0] x,
	input logic [7:0] y,
	input logic [7:0] opv,
	input logic c_in,
	output logic [7:0] res,
	output logic n,
	output logic v,
	output logic z,
	output logic c,
	output logic wr_a,
	output logic wr_x,
	output logic wr_y,
	output logic wr_mem,
	output logic upd_nz,
	output logic upd_v,
	output logic upd_c
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_zero(input logic [7:0] b);
		return b == 8'h00;
	endfunction

	// ----------------------------------------
	// Operations
	// ----------------------------------------
	always_comb begin
		logic [8:0] sum;
		logic [7:0] reg_op;
		cca_pkg::cca_op_e opc;
		sum = 9'h000;
		reg_op = a;
		opc = cca_pkg::cca_op_e'(op);
		res = a;
		v = 1'b0;
		c = c_in;
		wr_a = 1'b0;
		wr_x = 1'b0;
		wr_y = 1'b0;
		wr_mem = 1'b0;
		upd_nz = 1'b0;
		upd_v = 1'b0;
		upd_c = 1'b0;
		unique case (opc)
			cca_pkg::op_add_with_carry: begin
				sum = {1'b0, a} + {1'b0, opv} + {8'h00, c_in}; // RULE_10
				res = sum[7:0];
				c = sum[8];
				v = (a[7] == opv[7]) && (res[7] != a[7]);
				wr_a = 1'b1; // RULE_09
				{upd_nz, upd_v, upd_c} = 3'h7;
			end
			cca_pkg::op_subtract_with_borrow: begin
				// Carry set means no borrow pending, so the sum of the complement is exact.
				sum = {1'b0, a} + {1'b0, ~opv} + {8'h00, c_in}; // RULE_11
				res = sum[7:0];
				c = sum[8];
				v = (a[7] != opv[7]) && (res[7] != a[7]);
				wr_a = 1'b1;
				{upd_nz, upd_v, upd_c} = 3'h7;
			end
			cca_pkg::op_and_acc: begin
				res = a & opv; // RULE_12
				wr_a = 1'b1;
				upd_nz = 1'b1;
			end
			cca_pkg::op_inclusive_or_accumulate: begin
				res = a | opv; // RULE_14
				wr_a = 1'b1;
				upd_nz = 1'b1;
			end
			cca_pkg::op_exclusive_or: begin
				res = a ^ opv; // RULE_13
				wr_a = 1'b1;
				upd_nz = 1'b1;
			end
			cca_pkg::op_bit_test: begin
				res = a & opv; // RULE_19
				upd_nz = 1'b1;
				upd_v = 1'b1;
				v = opv[6]; // RULE_15
			end
			cca_pkg::op_compare_accumulator, cca_pkg::op_compare_x_index,
			cca_pkg::op_compare_y_index: begin
				reg_op = (opc == cca_pkg::op_compare_x_index) ? x :
					(opc == cca_pkg::op_compare_y_index) ? y : a; // RULE_07
				sum = {1'b0, reg_op} + {1'b0, ~opv} + 9'h001; // RULE_06
				res = sum[7:0];
				c = sum[8]; // RULE_20
				upd_nz = 1'b1;
				upd_c = 1'b1;
			end
			cca_pkg::op_memory_plus_one, cca_pkg::op_memory_minus_one: begin
				res = (opc == cca_pkg::op_memory_plus_one) ? opv + 8'h01 : opv - 8'h01; // RULE_02
				wr_mem = 1'b1; // RULE_05
				upd_nz = 1'b1;
			end
			cca_pkg::op_x_index_plus_one, cca_pkg::op_x_index_minus_one: begin
				res = (opc == cca_pkg::op_x_index_plus_one) ? x + 8'h01 : x - 8'h01; // RULE_03
				wr_x = 1'b1;
				upd_nz = 1'b1;
			end
			cca_pkg::op_y_index_plus_one, cca_pkg::op_y_index_minus_one: begin
				res = (opc == cca_pkg::op_y_index_plus_one) ? y + 8'h01 : y - 8'h01; // RULE_03
				wr_y = 1'b1;
				upd_nz = 1'b1;
			end
			cca_pkg::op_clear_carry_op: begin
				c = 1'b0;
				upd_c = 1'b1;
			end
			cca_pkg::op_set_carry_op: begin
				c = 1'b1;
				upd_c = 1'b1;
			end
			default: begin
				res = a;
			end
		endcase
		n = (opc == cca_pkg::op_bit_test) ? opv[7] : res[7]; // RULE_21
		z = is_zero(res); // RULE_18
	end

endmodule

// ### test/cpu_counter_compare_alu_tb_top.sv
`timescale 1ns/1ps
`include "cca_params.svh"

module cpu_counter_compare_alu_tb_top;
	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	logic clk;
	logic rst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [15:0] mem_addr;
	logic mem_rd;
	logic mem_wr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic busy;
	logic rd_q;
	logic [7:0] mem [0:65535];
	logic [7:0] rd_exp_q[$];
	logic [23:0] wr_exp_q[$];
	logic [7:0] a, x, y, res;
	logic fn, fv, fz, fc;
	int error_cnt;
	int n_tests;

	cca_top i_cca_top (
		.clk(clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.mem_addr(mem_addr),
		.mem_rd(mem_rd),
		.mem_wr(mem_wr),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.busy(busy)
	);

	always #25 clk = ~clk;

	// ----------------------------------------
	// Memory and result monitor
	// ----------------------------------------
	// Outside a read answer the data lines toggle, so a late sample cannot match by luck.
	always @(posedge clk) begin
		rd_q <= reg_rd;
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	always @(negedge clk) begin
		if (rd_q) begin
			if (rd_exp_q.size() == 0) mism("read without note");
			else check({16'h0, reg_rdata}, {16'h0, rd_exp_q.pop_front()});
		end
		if (mem_wr === 1'b1) begin
			if (wr_exp_q.size() == 0) mism("memory written unexpectedly");
			else check({mem_addr, mem_wdata}, wr_exp_q.pop_front());
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic mism(input string s);
		error_cnt++;
		$display("MISMATCH t=%0t %s", $time, s);
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		rd_exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			if (busy === 1'b0) break;
		end
		if (i == 12) mism("busy stuck");
	endtask

	task automatic run(input int op);
		wr(`CCA_REG_CMD, 8'(op));
		wait_idle();
	endtask

	task automatic load(input logic [7:0] av, xv, yv, st);
		wr(`CCA_REG_ACC, av);
		wr(`CCA_REG_X, xv);
		wr(`CCA_REG_Y, yv);
		wr(`CCA_REG_STATUS, st);
		{a, x, y} = {av, xv, yv};
		{fn, fv, fz, fc} = {st[7], st[6], st[1], st[0]};
	endtask

	task automatic opnd(input int md, input logic [7:0] m, input logic [15:0] ad);
		wr(`CCA_REG_MODE, 8'(md));
		if (md == 0) wr(`CCA_REG_IMM, m);
		else begin
			mem[(md == 1) ? {8'h00, ad[7:0]} : ad] = m;
			wr(`CCA_REG_ADDR_LO, ad[7:0]);
			wr(`CCA_REG_ADDR_HI, ad[15:8]);
		end
	endtask

	task automatic chk();
		rd(`CCA_REG_ACC, a);
		rd(`CCA_REG_X, x);
		rd(`CCA_REG_Y, y);
		rd(`CCA_REG_STATUS, {fn, fv, 4'h0, fz, fc});
	endtask

	task automatic model(input int op, input logic [7:0] m);
		logic [7:0] mm, rv;
		logic [8:0] s;
		mm = (op == 1) ? ~m : m;
		rv = (op == 6) ? a : ((op == 7) ? x : y);
		s = {1'b0, a} + {1'b0, mm} + {8'h00, fc};
		case (op)
			0, 1: begin
				res = s[7:0];
				fv = (a[7] == mm[7]) && (res[7] != a[7]);
				fc = s[8];
				a = res;
			end
			2: a = a & m;
			3: a = a | m;
			4: a = a ^ m;
			5: res = a & m;
			6, 7, 8: begin
				res = rv - m;
				fc = rv >= m;
			end
			9: res = m + 8'h01;
			10: res = m - 8'h01;
			11: x = x + 8'h01;
			12: x = x - 8'h01;
			13: y = y + 8'h01;
			14: y = y - 8'h01;
			15: fc = 1'b0;
			16: fc = 1'b1;
			default: res = 8'h00;
		endcase
		if (op >= 2 && op <= 4) res = a;
		if (op >= 11 && op <= 14) res = (op < 13) ? x : y;
		if (op == 5) {fn, fv, fz} = {m[7], m[6], res == 8'h00};
		else if (op < 15) {fn, fz} = {res[7], res == 8'h00};
	endtask

	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] m;
		logic [15:0] ad;
		int op;
		{clk, rst, reg_addr, reg_wdata, reg_wr, reg_rd, rd_q} = {2'b01, 4'h0, 8'h00, 3'b000};
		mem_rdata = 8'h00;
		error_cnt = 0;
		n_tests = 0;
		void'($urandom(32'h4e2f));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) rd(4'(i), (i == 8) ? 8'h11 : 8'h00);
		rd(4'hf, 8'h00);
		for (int k = 0; k < 40; k++) begin
			op = k % 5;
			m = (k < 5) ? 8'h00 : 8'($urandom);
			load((k < 5) ? 8'hff : 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom) & 8'hc3);
			opnd(0, m, 16'h0000);
			run(op);
			model(op, m);
			chk();
			rd(`CCA_REG_RESULT, res);
		end
		for (int k = 0; k < 24; k++) begin
			op = 5 + k % 4;
			load(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom) & 8'hc3);
			m = (k % 3 == 0) ? ((op == 7) ? x : ((op == 8) ? y : a)) : 8'($urandom);
			opnd((k / 4) % 3, m, 16'($urandom));
			run(op);
			model(op, m);
			chk();
		end
		for (int k = 0; k < 8; k++) begin
			op = 9 + k % 2;
			m = (k < 2) ? ((op == 9) ? 8'hff : 8'h00) : 8'($urandom);
			ad = 16'($urandom);
			opnd(1 + (k / 2) % 2, m, ad);
			model(op, m);
			wr_exp_q.push_back({((k / 2) % 2 == 0) ? {8'h00, ad[7:0]} : ad, res});
			run(op);
			chk();
		end
		opnd(0, 8'h06, 16'h0000);
		run(15);
		run(0);
		model(15, 8'h00);
		model(0, 8'h06);
		chk();
		rd(`CCA_REG_RESULT, res);
		run(16);
		run(1);
		model(16, 8'h00);
		model(1, 8'h06);
		chk();
		rd(`CCA_REG_RESULT, res);
		load(8'h3c, 8'hff, 8'hff, 8'h00);
		for (op = 11; op <= 16; op++) begin
			run(op);
			model(op, 8'h00);
			chk();
		end
		// Refused requests leave state alone and never touch memory.
		opnd(0, 8'h77, 16'h0000);
		run(9);
		rd(`CCA_REG_CMD, 8'h10);
		wr(`CCA_REG_MODE, 8'h03);
		rd(`CCA_REG_MODE, 8'h00);
		m = 8'($urandom);
		opnd(2, m, 16'hbe21);
		wr(`CCA_REG_CMD, 8'h06);
		wr(`CCA_REG_ACC, 8'h5a);
		wait_idle();
		model(6, m);
		chk();
		if (wr_exp_q.size() != 0) mism("memory write missing");
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mism("watchdog expired");
		test_done();
	end
endmodule
